// ### include/bufctl_pkg.sv
// Shared constants for the buffer pair control block
package bufctl_pkg;

    // Register offsets (word addresses on the plain port)
    localparam logic [3:0] OFF_PAIR_CTRL0 = 4'h0;   // Pairs 0..3 at 0..3
    localparam logic [3:0] OFF_IRQ_STATUS = 4'h4;
    localparam logic [3:0] OFF_IRQ_MASK   = 4'h5;
    localparam logic [3:0] OFF_BUF_BASE   = 4'h6;
    localparam logic [3:0] OFF_BUF_SIZE   = 4'h7;
    localparam logic [3:0] OFF_WORD0      = 4'h8;   // Header word of selected buffer
    localparam logic [3:0] OFF_WORD0_SEL  = 4'h9;

    localparam int NUM_BUF  = 8;
    localparam int NUM_PAIR = 4;

    // Control byte field positions
    localparam int BIT_DIR   = 7;
    localparam int BIT_ABT   = 6;
    localparam int BIT_LARB  = 5;
    localparam int BIT_ERR   = 4;
    localparam int BIT_REQ   = 3;
    localparam int BIT_RTREN = 2;
    localparam int PRI_HI    = 1;
    localparam int PRI_LO    = 0;

    // Header word field positions
    localparam int W0_SID_HI = 12;
    localparam int W0_SID_LO = 2;
    localparam int W0_SRR    = 1;
    localparam int W0_IDE    = 0;

    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [15:0] BUF_BASE_RST  = 16'h0000;
    localparam logic [15:0] BUF_SIZE_RST  = 16'h0020;
    localparam logic [15:0] WORD0_IMPL    = 16'h1fff;

    // Interrupt status layout: [7:0] sent, [15:8] aborted
    localparam int IRQ_SENT_LO = 0;
    localparam int IRQ_ABT_LO  = 8;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_BUSY = 2'b01
    } tx_state_e;

endpackage : bufctl_pkg

// ### verilog/tx_pick.sv
// Priority selection among pending transmit buffers
`timescale 1ns/1ps
module tx_pick
    import bufctl_pkg::*;
(
    input  wire logic [NUM_BUF-1:0]   pending_i,
    input  wire logic [2*NUM_BUF-1:0] prio_i,
    output logic                      found_o,
    output logic [2:0]                index_o
);
    // Highest priority wins; higher index breaks ties
    always_comb
    begin
        found_o = 1'b0;
        index_o = 3'd0;
        for (int p = 3; p >= 0; p--)
        begin
            for (int b = NUM_BUF - 1; b >= 0; b--)
            begin
                if (pending_i[b] && prio_i[2*b +: 2] == 2'(p) && !found_o)
                begin
                    found_o = 1'b1;
                    index_o = 3'(b);
                end
            end
            if (found_o)
            begin
                break;
            end
        end
    end
endmodule : tx_pick

// ### verilog/word0_fmt.sv
// Header word packing with unimplemented bits forced low
`timescale 1ns/1ps
module word0_fmt
    import bufctl_pkg::*;
(
    input  wire logic [15:0] raw_i,
    output logic [10:0]      sid_o,
    output logic             srr_o,
    output logic             ide_o,
    output logic [15:0]      word_o
);
    assign sid_o  = raw_i[W0_SID_HI:W0_SID_LO];
    assign srr_o  = raw_i[W0_SRR];
    assign ide_o  = raw_i[W0_IDE];
    assign word_o = raw_i & WORD0_IMPL;
endmodule : word0_fmt

// ### verilog/buf_pair_ctrl.sv
// Control and status of eight message buffers held as four pairs
//
// Operation
// - Direction bit 7: one makes a transmit buffer, zero a receive buffer.
// - Aborted flag bit 6 set on abort, stays zero on success.
// - Arbitration-lost flag bit 5 set when bus arbitration was lost.
// - Bus-error flag bit 4 set on error during transmission.
// - Send request bit 3: set queues, hardware clears on success, zero aborts.
// - Setting send request clears the three status flags of that buffer.
// - Buffer area base and size set by software; accesses stay inside.
// - Header word bits 15 to 13 read as zero.
// - Header word bits 12 to 2 hold the standard identifier.
// - Header bit 1 marks a remote transmission request.
// - Header bit 0 selects extended frame format.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module buf_pair_ctrl
    import bufctl_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // Register port
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [15:0]      rdata_o,
    output logic             irq_o,
    // Protocol engine side
    output logic             tx_start_o,
    output logic [2:0]       tx_index_o,
    output logic [15:0]      tx_addr_o,
    output logic             tx_abort_o,
    input  wire logic        tx_done_i,
    input  wire logic        tx_arb_lost_i,
    input  wire logic        tx_bus_err_i,
    input  wire logic        rtr_rx_i,
    input  wire logic [2:0]  rtr_index_i,
    // DMA RAM header word returned for the selected buffer
    input  wire logic [15:0] word0_raw_i
);

    ////////////////////////////////////////////////////////////////////////
    // Control bytes, one per buffer

    logic [7:0]          ctrl [NUM_BUF];
    logic [15:0]         irq_status;
    logic [15:0]         irq_mask;
    logic [15:0]         buf_base;
    logic [15:0]         buf_size;
    logic [2:0]          word0_sel;
    tx_state_e           tx_state;
    logic [2:0]          active;
    logic [NUM_BUF-1:0]  pending;
    logic [2*NUM_BUF-1:0] prio;
    logic                found;
    logic [2:0]          pick;
    logic [15:0]         word0;
    logic [15:0]         next_rdata;

    function automatic logic ctrl_hit(input logic [3:0] a);
        ctrl_hit = (a < 4'(NUM_PAIR));
    endfunction : ctrl_hit

    generate
        for (genvar b = 0; b < NUM_BUF; b++)
        begin : g_buf
            // Even buffer uses low byte, odd buffer uses high byte
            localparam int LANE = (b % 2) * 8;
            localparam logic [3:0] PAIR = 4'(b / 2);
            logic sw_wr;
            logic [7:0] wb;
            logic ev_done;
            logic ev_fail;
            assign sw_wr  = wr_i && ctrl_hit(addr_i) && addr_i == PAIR;
            assign wb     = wdata_i[LANE +: 8];
            assign ev_done = tx_state == TX_BUSY && active == 3'(b) && tx_done_i;
            assign ev_fail = tx_state == TX_BUSY && active == 3'(b)
                             && (tx_arb_lost_i || tx_bus_err_i);
            assign pending[b] = ctrl[b][BIT_DIR] && ctrl[b][BIT_REQ];
            assign prio[2*b +: 2] = ctrl[b][PRI_HI:PRI_LO];

            always_ff @(posedge clk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                begin
                    ctrl[b] <= CTRL_RESET;
                end
                else
                begin
                    if (sw_wr)
                    begin
                        ctrl[b][BIT_DIR]         <= wb[BIT_DIR];
                        ctrl[b][BIT_RTREN]       <= wb[BIT_RTREN];
                        ctrl[b][PRI_HI:PRI_LO]   <= wb[PRI_HI:PRI_LO];
                        ctrl[b][BIT_REQ]         <= wb[BIT_REQ];
                        if (wb[BIT_REQ])
                        begin
                            ctrl[b][BIT_ABT]  <= 1'b0;
                            ctrl[b][BIT_LARB] <= 1'b0;
                            ctrl[b][BIT_ERR]  <= 1'b0;
                        end
                        else if (ctrl[b][BIT_REQ])
                        begin
                            ctrl[b][BIT_ABT] <= 1'b1;
                        end
                    end
                    else if (ev_done)
                    begin
                        ctrl[b][BIT_REQ] <= 1'b0;
                    end
                    else if (rtr_rx_i && rtr_index_i == 3'(b)
                             && ctrl[b][BIT_RTREN] && ctrl[b][BIT_DIR])
                    begin
                        ctrl[b][BIT_REQ] <= 1'b1;
                        ctrl[b][BIT_ABT] <= 1'b0;
                        ctrl[b][BIT_LARB] <= 1'b0;
                        ctrl[b][BIT_ERR] <= 1'b0;
                    end
                    // Failures keep the request so the engine retries
                    // Hardware set wins unless the same write re-arms the request
                    if (ev_fail && !(sw_wr && wb[BIT_REQ]))
                    begin
                        if (tx_arb_lost_i)
                        begin
                            ctrl[b][BIT_LARB] <= 1'b1;
                        end
                        if (tx_bus_err_i)
                        begin
                            ctrl[b][BIT_ERR] <= 1'b1;
                        end
                    end
                end
            end
        end
    endgenerate

    tx_pick u_pick (
        .pending_i (pending),
        .prio_i    (prio),
        .found_o   (found),
        .index_o   (pick)
    );

    word0_fmt u_word0 (
        .raw_i  (word0_raw_i),
        .sid_o  (),
        .srr_o  (),
        .ide_o  (),
        .word_o (word0)
    );

    ////////////////////////////////////////////////////////////////////////
    // Transmit sequencing

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            tx_state   <= TX_IDLE;
            active     <= 3'd0;
            tx_start_o <= 1'b0;
            tx_abort_o <= 1'b0;
            tx_index_o <= 3'd0;
            tx_addr_o  <= 16'h0000;
        end
        else
        begin
            tx_start_o <= 1'b0;
            tx_abort_o <= 1'b0;
            case (tx_state)
                TX_IDLE:
                begin
                    if (found)
                    begin
                        tx_state   <= TX_BUSY;
                        active     <= pick;
                        tx_start_o <= 1'b1;
                        tx_index_o <= pick;
                        // Wraps inside the software area
                        tx_addr_o  <= buf_base
                                      + ((16'(pick) * 16'h0008) % buf_size);
                    end
                end
                TX_BUSY:
                begin
                    if (tx_done_i || tx_arb_lost_i || tx_bus_err_i)
                    begin
                        tx_state <= TX_IDLE;
                    end
                    else if (!ctrl[active][BIT_REQ])
                    begin
                        tx_state   <= TX_IDLE;
                        tx_abort_o <= 1'b1;
                    end
                end
                default:
                begin
                    tx_state <= TX_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration and interrupt registers

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            irq_mask  <= 16'h0000;
            buf_base  <= BUF_BASE_RST;
            buf_size  <= BUF_SIZE_RST;
            word0_sel <= 3'd0;
        end
        else if (wr_i)
        begin
            if (addr_i == OFF_IRQ_MASK)
            begin
                irq_mask <= wdata_i;
            end
            else if (addr_i == OFF_BUF_BASE)
            begin
                buf_base <= wdata_i;
            end
            else if (addr_i == OFF_BUF_SIZE && wdata_i != 16'h0000)
            begin
                buf_size <= wdata_i;
            end
            else if (addr_i == OFF_WORD0_SEL)
            begin
                word0_sel <= wdata_i[2:0];
            end
        end
    end

    // Set wins over write-one-to-clear
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            irq_status <= 16'h0000;
        end
        else
        begin
            for (int b = 0; b < NUM_BUF; b++)
            begin
                if (wr_i && addr_i == OFF_IRQ_STATUS && wdata_i[IRQ_SENT_LO + b])
                begin
                    irq_status[IRQ_SENT_LO + b] <= 1'b0;
                end
                if (wr_i && addr_i == OFF_IRQ_STATUS && wdata_i[IRQ_ABT_LO + b])
                begin
                    irq_status[IRQ_ABT_LO + b] <= 1'b0;
                end
                if (tx_state == TX_BUSY && active == 3'(b) && tx_done_i)
                begin
                    irq_status[IRQ_SENT_LO + b] <= 1'b1;
                end
                if (tx_state == TX_BUSY && active == 3'(b) && !tx_done_i
                    && !tx_arb_lost_i && !tx_bus_err_i && !ctrl[b][BIT_REQ])
                begin
                    irq_status[IRQ_ABT_LO + b] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            irq_o <= 1'b0;
        end
        else
        begin
            irq_o <= |(irq_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    always_comb
    begin
        next_rdata = 16'h0000;
        if (ctrl_hit(addr_i))
        begin
            next_rdata = {ctrl[{addr_i[1:0], 1'b1}], ctrl[{addr_i[1:0], 1'b0}]};
        end
        else if (addr_i == OFF_IRQ_STATUS)
        begin
            next_rdata = irq_status;
        end
        else if (addr_i == OFF_IRQ_MASK)
        begin
            next_rdata = irq_mask;
        end
        else if (addr_i == OFF_BUF_BASE)
        begin
            next_rdata = buf_base;
        end
        else if (addr_i == OFF_BUF_SIZE)
        begin
            next_rdata = buf_size;
        end
        else if (addr_i == OFF_WORD0)
        begin
            next_rdata = word0;
        end
        else if (addr_i == OFF_WORD0_SEL)
        begin
            next_rdata = {13'h0000, word0_sel};
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdata_o <= 16'h0000;
        end
        else
        begin
            rdata_o <= rd_i ? next_rdata : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    chk_req_clears_flags: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (wr_i && addr_i == OFF_PAIR_CTRL0 && wdata_i[BIT_REQ])
        |=> (ctrl[0][BIT_ABT] == 1'b0 && ctrl[0][BIT_ERR] == 1'b0))
        else $error("status flags not cleared by send request");

    chk_done_clears_req: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (tx_state == TX_BUSY && tx_done_i && !(wr_i && ctrl_hit(addr_i)))
        |=> !ctrl[active][BIT_REQ])
        else $error("send request not cleared after success");

    chk_rx_no_start: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        tx_start_o |-> ctrl[tx_index_o][BIT_DIR])
        else $error("receive buffer started a transmission");

    chk_word0_upper: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (rd_i && addr_i == OFF_WORD0) |=> rdata_o[15:13] == 3'b000)
        else $error("unimplemented header bits read nonzero");

    chk_abort_sets_flag: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (wr_i && addr_i == OFF_PAIR_CTRL0 && !wdata_i[BIT_REQ] && ctrl[0][BIT_REQ])
        |=> ctrl[0][BIT_ABT])
        else $error("aborted flag not set by withdrawn request");

    chk_arb_sets_flag: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (tx_state == TX_BUSY && active == 3'd0 && tx_arb_lost_i
         && !(wr_i && addr_i == OFF_PAIR_CTRL0 && wdata_i[BIT_REQ]))
        |=> ctrl[0][BIT_LARB])
        else $error("arbitration-lost flag not set");

endmodule : buf_pair_ctrl

// ### tb/can_engine_model.sv
// Behavioural model of the protocol engine that faces the CAN bus
`timescale 1ns/1ps
module can_engine_model
(
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       tx_start_i,
    input  wire logic       tx_abort_i,
    input  wire logic [1:0] mode_i,
    input  wire logic [3:0] delay_i,
    output logic            tx_done_o,
    output logic            tx_arb_lost_o,
    output logic            tx_bus_err_o
);
    logic       busy;
    logic [3:0] cnt;

    // Mode 3 leaves the frame hanging until software withdraws it
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            busy          <= 1'b0;
            cnt           <= 4'h0;
            tx_done_o     <= 1'b0;
            tx_arb_lost_o <= 1'b0;
            tx_bus_err_o  <= 1'b0;
        end
        else
        begin
            tx_done_o     <= 1'b0;
            tx_arb_lost_o <= 1'b0;
            tx_bus_err_o  <= 1'b0;
            if (tx_abort_i)
                busy <= 1'b0;
            else if (tx_start_i)
            begin
                busy <= (mode_i != 2'h3);
                cnt  <= delay_i;
            end
            else if (busy && cnt != 4'h0)
                cnt <= cnt - 4'h1;
            else if (busy)
            begin
                busy          <= 1'b0;
                tx_done_o     <= (mode_i == 2'h0);
                tx_arb_lost_o <= (mode_i == 2'h1);
                tx_bus_err_o  <= (mode_i == 2'h2);
            end
        end
    end
endmodule : can_engine_model

// ### tb/tb.sv
// Self-checking bench for the buffer pair control block
`timescale 1ns/1ps
module tb;
    import bufctl_pkg::*;
    logic        clk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic        rtr_rx_i = 1'b0, rd_q = 1'b0;
    logic [3:0]  addr_i = 4'h0;
    logic [3:0]  delay = 4'h1;
    logic [1:0]  mode = 2'h0;
    logic [2:0]  rtr_index_i = 3'h0;
    logic [15:0] wdata_i = 16'h0000, word0_raw_i = 16'h0000, rdata_o, tx_addr_o, w;
    logic [2:0]  tx_index_o;
    logic        irq_o, tx_start_o, tx_abort_o, tx_done_i, tx_arb_lost_i, tx_bus_err_i;
    logic [15:0] rq[$];
    logic [18:0] sq[$];
    int          ev[4];
    int          err_total = 0, n_tests = 0, i;
    int          seed = 32'hcaf5_6e5a;

    buf_pair_ctrl u_buf_pair_ctrl (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
        .tx_start_o(tx_start_o), .tx_index_o(tx_index_o), .tx_addr_o(tx_addr_o),
        .tx_abort_o(tx_abort_o), .tx_done_i(tx_done_i), .tx_arb_lost_i(tx_arb_lost_i),
        .tx_bus_err_i(tx_bus_err_i), .rtr_rx_i(rtr_rx_i), .rtr_index_i(rtr_index_i),
        .word0_raw_i(word0_raw_i));
    can_engine_model u_can_engine_model (.clk_i(clk_i), .resetn_i(resetn_i),
        .tx_start_i(tx_start_o), .tx_abort_i(tx_abort_o), .mode_i(mode), .delay_i(delay),
        .tx_done_o(tx_done_i), .tx_arb_lost_o(tx_arb_lost_i), .tx_bus_err_o(tx_bus_err_i));

    always #50 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("compares %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic chk(input logic [18:0] got, input logic [18:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_read(input logic [15:0] got, input logic [15:0] exp);
        chk({3'h0, got}, {3'h0, exp});
    endtask : chk_read

    task automatic chk_start(input logic [18:0] got, input logic [18:0] exp);
        chk(got, exp);
    endtask : chk_start

    task automatic chk_irq(input logic got, input logic exp);
        chk({18'h0, got}, {18'h0, exp});
    endtask : chk_irq

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        rd_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        rq.push_back(exp);
        addr_i <= a;
        rd_i <= 1'b1;
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask : rd

    task automatic idle;
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge clk_i);
    endtask : idle

    // Bounded wait on an event count (0 start, 1 done, 2 failure, 3 abort)
    task automatic wait_ev(input int k, input int t);
        int n;
        for (n = 0; n < 300 && ev[k] < t; n++)
            @(posedge clk_i);
        if (ev[k] < t)
        begin
            err_total++;
            $display("Error at %0t: event %0d never came", $time, k);
            test_done();
        end
    endtask : wait_ev

    // Strobes drop first; the level is sampled away from the launching edge
    task automatic wait_irq(input logic lvl);
        int n;
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(negedge clk_i);
        for (n = 0; n < 20 && irq_o !== lvl; n++)
            @(negedge clk_i);
        chk_irq(irq_o, lvl);
        if (irq_o !== lvl)
            test_done();
        else
            @(posedge clk_i);
    endtask : wait_irq

    ////////////////////////////////////////////////////////////////////////////////
    // Read data stand only in the cycle after the strobe
    always @(posedge clk_i)
        rd_q <= rd_i;

    always @(negedge clk_i)
    begin
        if (rd_q)
            chk_read(rdata_o, rq.pop_front());
        if (tx_start_o === 1'b1)
        begin
            ev[0]++;
            if (sq.size() == 0)
                chk_start(19'h7_ffff, {tx_index_o, tx_addr_o});
            else
                chk_start({tx_index_o, tx_addr_o}, sq.pop_front());
        end
        ev[1] += int'(tx_done_i);
        ev[2] += int'(tx_arb_lost_i | tx_bus_err_i);
        ev[3] += int'(tx_abort_o === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        for (i = 0; i < 4; i++)
            rd(i[3:0], 16'h0000);
        rd(OFF_BUF_SIZE, 16'h0020);
        wr(OFF_PAIR_CTRL0, 16'h7070);
        wr(OFF_BUF_SIZE, 16'h0000);
        wr(4'hA, 16'hffff);
        rd(OFF_PAIR_CTRL0, 16'h0000);
        rd(OFF_BUF_SIZE, 16'h0020);
        rd(4'hA, 16'h0000);
        wr(OFF_BUF_BASE, 16'h0100);
        $display("test reset_map done");
        for (i = 0; i < 6; i++)
        begin
            w = (i == 0) ? 16'hffff : 16'($random(seed));
            word0_raw_i <= w;
            rd(OFF_WORD0, w & 16'h1fff);
        end
        $display("test header_word done");
        // Pair 1: buffer 3 priority 3 beats buffer 2 priority 1; pair 2 is a receiver
        wr(OFF_IRQ_MASK, 16'hffff);
        sq.push_back({3'h3, 16'h0118});
        sq.push_back({3'h2, 16'h0110});
        wr(4'h1, 16'h8b89);
        wr(4'h2, 16'h0008);
        idle();
        wait_ev(1, 2);
        rd(4'h1, 16'h8381);
        rd(OFF_IRQ_STATUS, 16'h000c);
        wait_irq(1'b1);
        wr(OFF_IRQ_STATUS, 16'h0008);
        rd(OFF_IRQ_STATUS, 16'h0004);
        wr(OFF_IRQ_STATUS, 16'h0004);
        idle();
        wait_irq(1'b0);
        $display("test priority_irq done");
        // Lost arbitration keeps the request; the engine retries
        mode <= 2'h1;
        delay <= 4'h6;
        sq.push_back({3'h0, 16'h0100});
        sq.push_back({3'h0, 16'h0100});
        wr(OFF_PAIR_CTRL0, 16'h0088);
        idle();
        wait_ev(2, 1);
        mode <= 2'h3;
        wait_ev(0, 4);
        rd(OFF_PAIR_CTRL0, 16'h00a8);
        wr(OFF_IRQ_MASK, 16'h0000);
        wr(OFF_PAIR_CTRL0, 16'h0080);
        rd(OFF_PAIR_CTRL0, 16'h00e0);
        rd(OFF_IRQ_STATUS, 16'h0100);
        idle();
        wait_ev(3, 1);
        @(negedge clk_i);
        chk_irq(irq_o, 1'b0);
        @(posedge clk_i);
        wr(OFF_IRQ_MASK, 16'hff00);
        idle();
        wait_irq(1'b1);
        wr(OFF_IRQ_STATUS, 16'hffff);
        idle();
        wait_irq(1'b0);
        $display("test arbitration_abort done");
        // Bus error on the odd buffer, abort, then a clean resend
        mode <= 2'h2;
        delay <= 4'h3;
        sq.push_back({3'h1, 16'h0108});
        sq.push_back({3'h1, 16'h0108});
        wr(OFF_PAIR_CTRL0, 16'h8880);
        idle();
        wait_ev(2, 2);
        mode <= 2'h3;
        wait_ev(0, 6);
        rd(OFF_PAIR_CTRL0, 16'h98e0);
        wr(OFF_PAIR_CTRL0, 16'h8080);
        rd(OFF_PAIR_CTRL0, 16'hd0e0);
        idle();
        wait_ev(3, 2);
        mode <= 2'h0;
        delay <= 4'h1;
        sq.push_back({3'h1, 16'h0108});
        wr(OFF_PAIR_CTRL0, 16'h8880);
        rd(OFF_PAIR_CTRL0, 16'h88e0);
        idle();
        wait_ev(1, 3);
        rd(OFF_PAIR_CTRL0, 16'h80e0);
        $display("test error_resend done");
        // Remote frame for buffer 6 with auto reply enabled
        sq.push_back({3'h6, 16'h0110});
        wr(4'h3, 16'h0084);
        idle();
        rtr_rx_i <= 1'b1;
        rtr_index_i <= 3'h6;
        @(posedge clk_i);
        rtr_rx_i <= 1'b0;
        wait_ev(0, 8);
        wait_ev(1, 4);
        rd(4'h2, 16'h0008);
        idle();
        idle();
        $display("test remote_reply done");
        test_done();
    end
endmodule : tb
